// *** tws_pkg.sv ***
`default_nettype none
package tws_pkg;
    // mode value that selects two-wire master operation
    localparam logic [1:0] MODE_TWO_WIRE = 2'h3;
    // reference tick for the rate generator
    localparam int CLK_MHZ       = 250;
    localparam int REF_MHZ       = 12;
    // system clocks per reference tick: 250/12 truncates to 20
    localparam int REF_CYCLES    = CLK_MHZ / REF_MHZ;
    localparam logic [4:0] REF_DIV_LAST = 5'(REF_CYCLES - 1);
    localparam logic [3:0] LIN_RESET    = 4'he;
    localparam logic [3:0] EXP_RESET    = 4'h3;
    localparam logic [7:0] DATA_RESET   = 8'h00;
    localparam logic [2:0] BIT_LAST     = 3'h7;
    // event vector bit positions
    localparam int EV_COMMAND_FINISHED_FLAG = 0;
    localparam int EV_NACK   = 1;
    localparam int EV_BTF    = 2;
    localparam int EV_BRF    = 3;
    localparam int EV_OVR    = 4;
    localparam int EV_UDR    = 5;
    localparam int EV_W      = 6;
    typedef enum logic [2:0] {
        TWS_IDLE  = 3'b000,
        TWS_START = 3'b001,
        TWS_BIT   = 3'b011,
        TWS_ACK   = 3'b010,
        TWS_STOP  = 3'b110,
        TWS_DONE  = 3'b111
    } tws_state_t;
endpackage
`default_nettype wire

// *** tws_rate_gen.sv ***
`default_nettype none
module tws_rate_gen
    import tws_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       run,
    input  wire logic [3:0] lin,
    input  wire logic [3:0] expo,
    output logic            tick
);
    // 12 MHz tick from 250 MHz, then four quarter ticks per bit period
    // of (lin+1)*2^exp reference ticks; an accumulator spreads them so
    // odd periods stay exact; 250/12 is not integral, so about 4% fast;
    // periods under four reference ticks fall back to one per tick
    logic [4:0]  ref_q;
    logic [19:0] acc_q;
    wire         ref_tick = (ref_q == REF_DIV_LAST);
    wire [4:0]   lin_p1   = {1'b0, lin} + 5'h01;
    wire [19:0]  period   = {15'h0000, lin_p1} << expo;
    wire [19:0]  acc_sum  = acc_q + 20'h00004;
    wire         short_p  = (period < 20'h00004);
    wire         quarter  = ref_tick && (acc_sum >= period);
    wire [19:0]  acc_wrap = short_p ? 20'h00000 : acc_sum - period;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ref_q <= 5'h00;
            acc_q <= 20'h00000;
            tick  <= 1'b0;
        end else begin
            ref_q <= (ref_tick || !run) ? 5'h00 : ref_q + 5'h01;
            if (!run)
                acc_q <= 20'h00000;
            else if (quarter)
                acc_q <= acc_wrap;
            else if (ref_tick)
                acc_q <= acc_sum;
            tick <= run && quarter;
        end
    end
endmodule
`default_nettype wire

// *** tws_master.sv ***
`default_nettype none
module tws_master
    import tws_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       NRST,
    input  wire logic [1:0] MODE_SEL,
    input  wire logic [3:0] LIN_DIV,
    input  wire logic [3:0] EXP_DIV,
    input  wire logic       REQ_START,
    input  wire logic       REQ_TX,
    input  wire logic       REQ_RX,
    input  wire logic       REQ_STOP,
    input  wire logic       ACK_CTRL,
    input  wire logic       DATA_WE,
    input  wire logic [7:0] DATA_WDATA,
    input  wire logic       DATA_RE,
    input  wire logic       FLAG_CLR,
    input  wire logic [5:0] IRQ_EN,
    input  wire logic       SDA_I,
    input  wire logic       SCL_I,
    output logic            SDA_OE_N,
    output logic            SCL_OE_N,
    output logic            SDA_O,
    output logic            SCL_O,
    output logic [3:0]      REQ_PEND,
    output logic [7:0]      DATA_RDATA,
    output logic            CMD_DONE,
    output logic            TX_DONE,
    output logic            RX_DONE,
    output logic            NACK_FLAG,
    output logic            IRQ
);
    import tws_pkg::*;
    tws_state_t   st_q;
    logic [1:0]   ph_q;
    logic [2:0]   bit_q;
    logic [7:0]   data_q;
    logic [3:0]   req_q;
    logic [1:0]   sda_s_q;
    logic [1:0]   scl_s_q;
    logic         sda_lo_q;
    logic         scl_lo_q;
    logic         rx_full_q;
    logic         tx_full_q;
    logic [EV_W-1:0] ev_q;
    logic         tick;
    wire enabled  = (MODE_SEL == MODE_TWO_WIRE);
    wire sda_in   = sda_s_q[1];
    wire scl_in   = scl_s_q[1];
    // slave stretching holds the phase until scl is seen high
    wire adv      = tick && !(ph_q == 2'h2 && !scl_in);
    wire is_start = req_q[0];
    wire is_tx    = req_q[1];
    wire is_rx    = req_q[2];
    wire is_stop  = req_q[3];
    wire launch   = (st_q == TWS_IDLE) && (req_q != 4'h0) && enabled;
    wire bit_end  = adv && (ph_q == 2'h3);
    wire new_req  = REQ_START || REQ_TX || REQ_RX || REQ_STOP;
    wire [EV_W-1:0] ev_set;
    wire last_bit = (bit_q == BIT_LAST);
    assign ev_set[EV_COMMAND_FINISHED_FLAG] = (st_q == TWS_DONE) && (is_start || is_stop);
    assign ev_set[EV_BTF]    = (st_q == TWS_DONE) && is_tx;
    assign ev_set[EV_BRF]    = (st_q == TWS_DONE) && is_rx;
    assign ev_set[EV_NACK]   = (st_q == TWS_ACK) && is_tx && bit_end
                               && sda_in;
    // byte received while the last one was still unread
    assign ev_set[EV_OVR]    = ev_set[EV_BRF] && rx_full_q;
    // transmit launched with no fresh byte written
    assign ev_set[EV_UDR]    = launch && is_tx && !tx_full_q;
    tws_rate_gen u_rate (
        .clk  (CLK),
        .nrst (NRST),
        .run  (st_q != TWS_IDLE),
        .lin  (LIN_DIV),
        .expo (EXP_DIV),
        .tick (tick)
    );
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sda_s_q <= 2'b11;
            scl_s_q <= 2'b11;
        end else begin
            sda_s_q <= {sda_s_q[0], SDA_I};
            scl_s_q <= {scl_s_q[0], SCL_I};
        end
    end
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            st_q      <= TWS_IDLE;
            ph_q      <= 2'h0;
            bit_q     <= 3'h0;
            req_q     <= 4'h0;
            sda_lo_q  <= 1'b0;
            scl_lo_q  <= 1'b0;
            data_q    <= DATA_RESET;
            rx_full_q <= 1'b0;
            tx_full_q <= 1'b0;
            NACK_FLAG <= 1'b0;
        end else begin
            // a request while disabled is dropped, not left to fire later
            if (st_q == TWS_IDLE && new_req && enabled)
                req_q <= {REQ_STOP, REQ_RX, REQ_TX, REQ_START};
            if (DATA_WE && st_q == TWS_IDLE) begin
                data_q    <= DATA_WDATA;
                tx_full_q <= 1'b1;
            end
            if (DATA_RE)
                rx_full_q <= 1'b0;
            if (adv)
                ph_q <= ph_q + 2'h1;
            case (st_q)
                TWS_IDLE: begin
                    ph_q <= 2'h0;
                    if (launch) begin
                        bit_q <= 3'h0;
                        if (is_start)
                            st_q <= TWS_START;
                        else if (is_stop)
                            st_q <= TWS_STOP;
                        else begin
                            st_q <= TWS_BIT;
                            if (is_tx)
                                tx_full_q <= 1'b0;
                        end
                    end
                end
                TWS_START: if (adv) begin
                    // also a repeated start from a held-low clock
                    case (ph_q)
                        2'h0: sda_lo_q <= 1'b0;
                        2'h1: scl_lo_q <= 1'b0;
                        2'h2: sda_lo_q <= 1'b1;
                        default: begin
                            scl_lo_q <= 1'b1;
                            st_q     <= TWS_DONE;
                        end
                    endcase
                end
                TWS_BIT: if (adv) begin
                    case (ph_q)
                        2'h0: begin
                            scl_lo_q <= 1'b1;
                            sda_lo_q <= is_tx ? !data_q[7] : 1'b0;
                        end
                        2'h1: scl_lo_q <= 1'b0;
                        2'h2: if (is_rx)
                            data_q <= {data_q[6:0], sda_in};
                        default: begin
                            scl_lo_q <= 1'b1;
                            if (is_tx)
                                data_q <= {data_q[6:0], 1'b0};
                            bit_q <= bit_q + 3'h1;
                            if (last_bit)
                                st_q <= TWS_ACK;
                        end
                    endcase
                end
                TWS_ACK: if (adv) begin
                    case (ph_q)
                        2'h0: sda_lo_q <= is_rx && !ACK_CTRL;
                        2'h1: scl_lo_q <= 1'b0;
                        2'h2: ;
                        default: begin
                            scl_lo_q <= 1'b1;
                            NACK_FLAG <= sda_in;
                            st_q <= TWS_DONE;
                        end
                    endcase
                end
                TWS_STOP: if (adv) begin
                    case (ph_q)
                        2'h0: sda_lo_q <= 1'b1;
                        2'h1: scl_lo_q <= 1'b0;
                        2'h2: ;
                        default: begin
                            sda_lo_q <= 1'b0;
                            st_q     <= TWS_DONE;
                        end
                    endcase
                end
                TWS_DONE: begin
                    req_q <= 4'h0;
                    if (is_rx)
                        rx_full_q <= 1'b1;
                    st_q <= TWS_IDLE;
                end
                default: st_q <= TWS_IDLE;
            endcase
        end
    end
    // sticky events; a new event wins over the clear
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ev_q <= '0;
            IRQ  <= 1'b0;
        end else begin
            ev_q <= (FLAG_CLR ? '0 : ev_q) | ev_set;
            IRQ  <= |(ev_q & IRQ_EN);
        end
    end
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            SDA_OE_N   <= 1'b1;
            SCL_OE_N   <= 1'b1;
            SDA_O      <= 1'b0;
            SCL_O      <= 1'b0;
            REQ_PEND   <= 4'h0;
            DATA_RDATA <= DATA_RESET;
            CMD_DONE   <= 1'b0;
            TX_DONE    <= 1'b0;
            RX_DONE    <= 1'b0;
        end else begin
            SDA_OE_N   <= !(sda_lo_q && enabled);
            SCL_OE_N   <= !(scl_lo_q && enabled);
            SDA_O      <= 1'b0;
            SCL_O      <= 1'b0;
            REQ_PEND   <= req_q;
            DATA_RDATA <= data_q;
            CMD_DONE   <= ev_q[EV_COMMAND_FINISHED_FLAG];
            TX_DONE    <= ev_q[EV_BTF];
            RX_DONE    <= ev_q[EV_BRF];
        end
    end
    chk_done_clears: assert property (@(posedge CLK) disable iff (!NRST)
        st_q == TWS_DONE |=> req_q == 4'h0 ##1 REQ_PEND == 4'h0)
        else $error("request not cleared after done");
    chk_cmd_flag: assert property (@(posedge CLK) disable iff (!NRST)
        (st_q == TWS_DONE && (is_start || is_stop))
        |=> ev_q[EV_COMMAND_FINISHED_FLAG] ##1 CMD_DONE)
        else $error("finished flag missing");
    chk_tx_flag: assert property (@(posedge CLK) disable iff (!NRST)
        (st_q == TWS_DONE && is_tx) |=> ev_q[EV_BTF])
        else $error("transmitted flag missing");
    chk_rx_flag: assert property (@(posedge CLK) disable iff (!NRST)
        (st_q == TWS_DONE && is_rx) |=> ev_q[EV_BRF] && rx_full_q)
        else $error("received flag missing");
    chk_irq_gate: assert property (@(posedge CLK) disable iff (!NRST)
        $rose(IRQ) |-> |($past(ev_q) & $past(IRQ_EN)))
        else $error("interrupt without enabled event");
    chk_pins_off: assert property (@(posedge CLK) disable iff (!NRST)
        !enabled |=> SDA_OE_N && SCL_OE_N)
        else $error("pin driven while disabled");
    chk_sda_stable: assert property (@(posedge CLK) disable iff (!NRST)
        (st_q == TWS_BIT && !scl_lo_q && ph_q == 2'h2) |=> $stable(sda_lo_q))
        else $error("data moved while clock high");
    chk_rx_ack: assert property (@(posedge CLK) disable iff (!NRST)
        (st_q == TWS_ACK && is_rx && ph_q == 2'h1 && adv)
        |-> sda_lo_q == !ACK_CTRL)
        else $error("wrong receive acknowledge");
    chk_nack_ev: assert property (@(posedge CLK) disable iff (!NRST)
        (st_q == TWS_ACK && is_tx && bit_end && sda_in) |=> ev_q[EV_NACK])
        else $error("nack event missing");
endmodule
`default_nettype wire

// *** tws_slave_model.sv ***
`default_nettype none
module tws_slave_model (
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       rd_mode,
    input  wire logic       ack_en,
    input  wire logic [7:0] rd_byte,
    output logic            sda_low,
    output logic [7:0]      got,
    output logic            m_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    int n = 0;
    initial sda_low = 1'b0;
    initial got = 8'h00;
    initial m_ack = 1'b0;
    // start condition realigns the bit count
    always @(negedge sda) if (scl) n = 0;
    always @(posedge scl) begin
        if (n < 8) got = {got[6:0], sda};
        else m_ack = !sda;
        n = (n == 8) ? 0 : n + 1;
    end
    // only changes while clock low, so never fakes a start or stop
    always @(negedge scl or rd_mode or rd_byte or ack_en) begin
        if (!scl) sda_low = rd_mode ? (n < 8 && !rd_byte[7 - n])
                                    : (n == 8 && ack_en);
    end
endmodule
`default_nettype wire

// *** tws_master_test.sv ***
`default_nettype none
module tws_master_test;
    import tws_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]  mode_sel;
    logic [3:0]  lin, expo, req, pend;
    logic [7:0]  wdata, rdata, got, rd_byte;
    logic [5:0]  irq_en;
    logic        clk, nrst, ack_ctrl, data_we, data_re, flag_clr, irq;
    logic        sda_oe_n, scl_oe_n, sda_o, scl_o, sda_low, m_ack;
    logic        cmd_done, tx_done, rx_done, nack, rd_mode, ack_en;
    wire         scl = scl_oe_n;
    wire         sda = sda_oe_n & ~sda_low;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          t_prev = 0;
    int          t_last = 0;
    int          t_fall = 0;
    int          t_low = 0;
    logic [31:0] seed = 32'd90;
    logic [7:0]  exp_q[$];

    tws_master dut (
        .CLK(clk), .NRST(nrst), .MODE_SEL(mode_sel), .LIN_DIV(lin),
        .EXP_DIV(expo), .REQ_START(req[0]), .REQ_TX(req[1]),
        .REQ_RX(req[2]), .REQ_STOP(req[3]), .ACK_CTRL(ack_ctrl),
        .DATA_WE(data_we), .DATA_WDATA(wdata), .DATA_RE(data_re),
        .FLAG_CLR(flag_clr), .IRQ_EN(irq_en), .SDA_I(sda), .SCL_I(scl),
        .SDA_OE_N(sda_oe_n), .SCL_OE_N(scl_oe_n), .SDA_O(sda_o),
        .SCL_O(scl_o), .REQ_PEND(pend), .DATA_RDATA(rdata),
        .CMD_DONE(cmd_done), .TX_DONE(tx_done), .RX_DONE(rx_done),
        .NACK_FLAG(nack), .IRQ(irq)
    );
    tws_slave_model slave (
        .scl(scl), .sda(sda), .rd_mode(rd_mode), .ack_en(ack_en),
        .rd_byte(rd_byte), .sda_low(sda_low), .got(got), .m_ack(m_ack)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_mismatch++;
            conclude();
        end
    end
    always @(posedge scl) begin
        t_prev = t_last;
        t_last = cyc;
        t_low = cyc - t_fall;
    end
    always @(negedge scl) begin
        t_fall = cyc;
    end

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // clear flags, pulse one request, wait for it to finish
    task automatic seg(input int k);
        int w;
        flag_clr = 1'b1;
        tick();
        flag_clr = 1'b0;
        req[k] = 1'b1;
        tick();
        req = 4'h0;
        // pending bits show one cycle after the request is taken
        tick();
        chk({4'h0, pend}, 8'(1 << k));
        for (w = 0; w < 20000 && pend !== 4'h0; w++) tick();
        chk({4'h0, pend}, 8'h00);
    endtask
    task automatic tx(input logic [7:0] b, input logic ack);
        ack_en = ack;
        wdata = b;
        data_we = 1'b1;
        tick();
        data_we = 1'b0;
        exp_q.push_back(b);
        seg(1);
        chk(got, exp_q.pop_front());
        chk({7'h0, tx_done}, 8'h01);
        chk({7'h0, nack}, {7'h0, !ack});
    endtask
    task automatic rx(input logic ack);
        rd_byte = rnd();
        exp_q.push_back(rd_byte);
        ack_ctrl = ack;
        rd_mode = 1'b1;
        seg(2);
        rd_mode = 1'b0;
        chk(rdata, exp_q.pop_front());
        chk({7'h0, rx_done}, 8'h01);
        // a low ack_ctrl makes the master pull the ack bit low
        chk({7'h0, m_ack}, {7'h0, !ack});
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        nrst = 1'b0;
        mode_sel = 2'h0;
        lin = 4'he;
        expo = 4'h1;
        req = 4'h0;
        ack_ctrl = 1'b0;
        data_we = 1'b0;
        wdata = 8'h00;
        data_re = 1'b0;
        flag_clr = 1'b0;
        irq_en = 6'h00;
        rd_mode = 1'b0;
        ack_en = 1'b1;
        rd_byte = 8'h00;
        repeat (8) @(posedge clk);
        #1 nrst = 1'b1;
        tick();
        // wrong mode: request dropped, pins left released
        req[0] = 1'b1;
        tick();
        req = 4'h0;
        repeat (40) tick();
        chk({2'h0, pend, sda_oe_n, scl_oe_n}, 8'h03);
        mode_sel = MODE_TWO_WIRE;
        irq_en = 6'h01;
        seg(0);
        chk({7'h0, cmd_done}, 8'h01);
        chk({7'h0, irq}, 8'h01);
        irq_en = 6'h02;
        tx({7'h2a, 1'b0}, 1'b1);
        // fast-rate bit period, generator runs a few percent quick
        chk({7'h0, 1'(t_last - t_prev inside {[590:640]})}, 8'h01);
        // clock low time: half of the fast bit period
        chk({7'h0, 1'(t_low inside {[290:310]})}, 8'h01);
        lin = 4'h0;
        expo = 4'h0;
        tx(rnd(), 1'b0);
        chk({7'h0, irq}, 8'h01);
        irq_en = 6'h00;
        tick();
        tick();
        chk({7'h0, irq}, 8'h00);
        seg(0);
        tx({5'h1e, 2'h1, 1'b1}, 1'b1);
        tx(rnd(), 1'b1);
        irq_en = 6'h10;
        data_re = 1'b1;
        tick();
        data_re = 1'b0;
        rx(1'b1);
        chk({7'h0, irq}, 8'h00);
        rx(1'b0);
        chk({7'h0, irq}, 8'h01);
        seg(3);
        chk({7'h0, cmd_done}, 8'h01);
        irq_en = 6'h20;
        seg(0);
        seg(1);
        chk({7'h0, irq}, 8'h01);
        seg(3);
        chk({6'h0, sda_o, scl_o}, 8'h00);
        conclude();
    end
endmodule
`default_nettype wire
